// ### rtl/ea_consts.svh
// Constants for the effective-address generator and its register window.
`ifndef EA_CONSTS_SVH
`define EA_CONSTS_SVH
`define EA_OFS_CTRL 4'h0
`define EA_OFS_RING 4'h4
`define EA_OFS_STAT 4'h8
`define EA_CTRL_XRING 0
`define EA_CTRL_YRING 1
`define EA_CTRL_RST 2'h0
`define EA_RING_RST 32'h0000_0000
`define EA_STEP_BYTE 32'h0000_0001
`define EA_STEP_WORD 32'h0000_0002
`define EA_STEP_LONG 32'h0000_0004
`define EA_SINGLE_BASE 4'h2
`define EA_XPTR_BASE 4'h4
`define EA_YPTR_BASE 4'h6
`define EA_XIDX_REG 4'h8
`define EA_YIDX_REG 4'h9
`endif

// ### rtl/ea_pkg.sv
// Types shared by the effective-address generator and its users.
package ea_pkg;
  typedef enum logic [1:0] {CLS_CPU = 2'h0, CLS_DUAL = 2'h1, CLS_SINGLE = 2'h2, CLS_NONE = 2'h3} req_class_t;
  typedef enum logic [1:0] {CPU_DIRECT = 2'h0, CPU_INDIRECT = 2'h1, CPU_POSTINC = 2'h2, CPU_PREDEC = 2'h3} cpu_mode_t;
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2, SZ_RSVD = 2'h3} op_size_t;
  typedef enum logic [1:0] {UPD_NONE = 2'h0, UPD_INDEX = 2'h1, UPD_INC = 2'h2, UPD_DEC = 2'h3} ptr_update_t;
endpackage

// ### rtl/cpu_dsp_address_generator.sv
// Effective-address generator for CPU indirect modes and DSP X/Y and single transfers.
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`include "ea_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module cpu_dsp_address_generator #(
  parameter int ADDR_W = 32
) (
  input wire logic clock,
  input wire logic nrst,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Request from the instruction decoder, one cycle per request.
  input wire logic reqValid,
  input wire ea_pkg::req_class_t reqClass,
  input wire ea_pkg::cpu_mode_t cpuMode,
  input wire ea_pkg::op_size_t opSize,
  input wire logic [3:0] regSel,
  input wire ea_pkg::ptr_update_t xUpdate,
  input wire logic ySel,
  input wire ea_pkg::ptr_update_t yUpdate,
  input wire logic xDestSel,
  input wire logic yDestSel,
  // Combinational register-file reads.
  output logic [3:0] rdIdxA,
  input wire logic [ADDR_W-1:0] rdDataA,
  output logic [3:0] rdIdxB,
  input wire logic [ADDR_W-1:0] rdDataB,
  input wire logic [ADDR_W-1:0] xIndexData,
  input wire logic [ADDR_W-1:0] yIndexData,
  // Issue towards memory and back to the register file.
  output logic operandValid,
  output logic [ADDR_W-1:0] operandData,
  output logic cpuBusReq,
  output logic [ADDR_W-1:0] cpuBusAddr,
  output ea_pkg::op_size_t cpuBusSize,
  output logic xyBusReq,
  output logic [15:0] xBusAddr,
  output logic [15:0] yBusAddr,
  output logic xLoadSel,
  output logic yLoadSel,
  output logic wbEnA,
  output logic [3:0] wbIdxA,
  output logic [ADDR_W-1:0] wbDataA,
  output logic wbEnB,
  output logic [3:0] wbIdxB,
  output logic [ADDR_W-1:0] wbDataB
);

  // Software-visible state and the bus handshake.
  logic [1:0] ctrl_reg;
  logic [31:0] ring_reg;
  logic [15:0] issueCount_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  // Ring bounds and the pointer arithmetic.
  logic [15:0] ringStart;
  logic [15:0] ringEnd;
  logic xRing;
  logic yRing;
  logic [ADDR_W-1:0] cpuStep;
  logic [ADDR_W-1:0] singleStep;
  logic [ADDR_W-1:0] xStep;
  logic [ADDR_W-1:0] yStep;
  logic [ADDR_W-1:0] xPtrNext;
  logic [ADDR_W-1:0] yPtrNext;
  logic [ADDR_W-1:0] addr_next;
  logic [ADDR_W-1:0] wbDataA_next;
  logic wbEnA_next;
  logic wbEnB_next;
  // Request decode and the bus side.
  logic memReq;
  logic wbHit;
  logic [31:0] wbMask;
  logic [1:0] rstPipe_reg;
  logic coreNrst;

  // The reset pin is not tied to the clock; it asserts at once but is released through
  // two flops, so that every register leaves reset on the same edge.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end
  assign coreNrst = rstPipe_reg[1]; // Only the second flop is read by the rest of the block.

  // Ring bounds: start in the low half, end in the high half.
  assign ringStart = ring_reg[15:0];
  assign ringEnd = ring_reg[31:16];
  // Only one pointer may wrap; Y takes precedence when both enables are set.
  // Setting both is a software slip that is not refused; the X side simply stops wrapping.
  assign yRing = ctrl_reg[`EA_CTRL_YRING];
  assign xRing = ctrl_reg[`EA_CTRL_XRING] & ~yRing;

  // Register-file read indices follow the request in the same cycle.
  // The register file must answer combinationally; a registered read would cost a cycle.
  // The second port always points at R6 or R7, and only dual requests use it.
  always_comb begin
    rdIdxB = `EA_YPTR_BASE | {3'h0, ySel};
    unique case (reqClass)
      ea_pkg::CLS_DUAL: rdIdxA = `EA_XPTR_BASE | {3'h0, regSel[0]};
      ea_pkg::CLS_SINGLE: rdIdxA = `EA_SINGLE_BASE + {2'h0, regSel[1:0]};
      default: rdIdxA = regSel;
    endcase
  end

  // Step sizes for the CPU modes and the single transfers.
  always_comb begin
    unique case (opSize)
      ea_pkg::SZ_BYTE: cpuStep = `EA_STEP_BYTE;
      ea_pkg::SZ_WORD: cpuStep = `EA_STEP_WORD;
      default: cpuStep = `EA_STEP_LONG;
    endcase
    // Single transfers know only word and long; anything but long is a word.
    singleStep = (opSize == ea_pkg::SZ_LONG) ? `EA_STEP_LONG : `EA_STEP_WORD;
  end

  // X/Y increments are always one word because the X/Y memories are 16 bits wide.
  // There is no X/Y decrement; stepping down uses an index of minus two.
  always_comb begin
    xStep = (xUpdate == ea_pkg::UPD_INDEX) ? xIndexData : `EA_STEP_WORD;
    yStep = (yUpdate == ea_pkg::UPD_INDEX) ? yIndexData : `EA_STEP_WORD;
  end

  // X pointer update. A wrap replaces bits 15..1 only, so bit 0 and the upper half stay.
  // An index step that jumps over the end value never wraps; steps must land on it.
  always_comb begin
    xPtrNext = rdDataA + xStep;
    if (xRing && rdDataA[15:1] == ringEnd[15:1]) begin
      xPtrNext = {rdDataA[ADDR_W-1:16], ringStart[15:1], rdDataA[0]};
    end
  end

  // Y pointer update writes the low half only; the upper half is kept as read.
  // The low-half sum drops its carry, so the pointer never leaves its page.
  always_comb begin
    yPtrNext = {rdDataB[ADDR_W-1:16], rdDataB[15:0] + yStep[15:0]};
    if (yRing && rdDataB[15:1] == ringEnd[15:1]) begin
      yPtrNext = {rdDataB[ADDR_W-1:16], ringStart[15:1], rdDataB[0]};
    end
  end

  // Address selection and primary write-back value per request class.
  // Pre-decrement uses the stepped value, which puts the subtractor in the address path.
  always_comb begin
    addr_next = rdDataA;
    wbDataA_next = rdDataA;
    wbEnA_next = 1'b0;
    wbEnB_next = 1'b0;
    memReq = 1'b0;
    if (reqValid) begin
      unique case (reqClass)
        // CPU register-indirect modes.
        ea_pkg::CLS_CPU: begin
          unique case (cpuMode)
            ea_pkg::CPU_DIRECT: memReq = 1'b0;
            ea_pkg::CPU_INDIRECT: memReq = 1'b1;
            ea_pkg::CPU_POSTINC: begin
              memReq = 1'b1;
              wbEnA_next = 1'b1;
              wbDataA_next = rdDataA + cpuStep;
            end
            ea_pkg::CPU_PREDEC: begin
              memReq = 1'b1;
              wbEnA_next = 1'b1;
              addr_next = rdDataA - cpuStep;
              wbDataA_next = rdDataA - cpuStep;
            end
          endcase
        end
        // Single transfers over the CPU data bus.
        ea_pkg::CLS_SINGLE: begin
          memReq = 1'b1;
          unique case (xUpdate)
            ea_pkg::UPD_NONE: wbEnA_next = 1'b0;
            ea_pkg::UPD_INDEX: begin
              wbEnA_next = 1'b1;
              wbDataA_next = rdDataA + xIndexData;
            end
            ea_pkg::UPD_INC: begin
              wbEnA_next = 1'b1;
              wbDataA_next = rdDataA + singleStep;
            end
            ea_pkg::UPD_DEC: begin
              wbEnA_next = 1'b1;
              addr_next = rdDataA - singleStep;
              wbDataA_next = rdDataA - singleStep;
            end
          endcase
        end
        // Dual transfers over the X and Y buses.
        ea_pkg::CLS_DUAL: begin
          memReq = 1'b1;
          wbEnA_next = (xUpdate != ea_pkg::UPD_NONE);
          wbDataA_next = xPtrNext;
          wbEnB_next = (yUpdate != ea_pkg::UPD_NONE);
        end
        default: memReq = 1'b0;
      endcase
    end
  end

  // Direct mode hands the register value back as the operand.
  // Data fields load only with a request and then hold, so a late reader still sees them.
  always_ff @(posedge clock or negedge coreNrst) begin
    if (!coreNrst) begin
      operandValid <= 1'b0;
      operandData <= '0;
    end else begin
      operandValid <= reqValid && reqClass == ea_pkg::CLS_CPU && cpuMode == ea_pkg::CPU_DIRECT;
      if (reqValid) begin
        operandData <= rdDataA;
      end
    end
  end

  // CPU data bus issue, shared by the CPU modes and the single transfers.
  // Dual requests leave this bus idle; they ride the X and Y buses instead.
  always_ff @(posedge clock or negedge coreNrst) begin
    if (!coreNrst) begin
      cpuBusReq <= 1'b0;
      cpuBusAddr <= '0;
      cpuBusSize <= ea_pkg::SZ_WORD;
    end else begin
      cpuBusReq <= memReq && reqClass != ea_pkg::CLS_DUAL;
      if (reqValid) begin
        cpuBusAddr <= addr_next;
        if (reqClass == ea_pkg::CLS_SINGLE) begin
          cpuBusSize <= (opSize == ea_pkg::SZ_LONG) ? ea_pkg::SZ_LONG : ea_pkg::SZ_WORD;
        end else begin
          cpuBusSize <= opSize;
        end
      end
    end
  end

  // Dual issue: both buses in one cycle, pre-update pointers, bit 0 and upper half dropped.
  // Issuing from the old pointer value keeps the adders out of the bus address path.
  always_ff @(posedge clock or negedge coreNrst) begin
    if (!coreNrst) begin
      xyBusReq <= 1'b0;
      xBusAddr <= '0;
      yBusAddr <= '0;
      xLoadSel <= 1'b0;
      yLoadSel <= 1'b0;
    end else begin
      xyBusReq <= memReq && reqClass == ea_pkg::CLS_DUAL;
      if (reqValid) begin
        xBusAddr <= {rdDataA[15:1], 1'b0};
        yBusAddr <= {rdDataB[15:1], 1'b0};
        xLoadSel <= xDestSel;
        yLoadSel <= yDestSel;
      end
    end
  end

  // Write-backs leave in the same cycle as the address, one edge after the request is taken.
  // The register file stores them one edge later; a request right behind must be forwarded.
  always_ff @(posedge clock or negedge coreNrst) begin
    if (!coreNrst) begin
      wbEnA <= 1'b0;
      wbIdxA <= '0;
      wbDataA <= '0;
      wbEnB <= 1'b0;
      wbIdxB <= '0;
      wbDataB <= '0;
    end else begin
      wbEnA <= wbEnA_next;
      wbEnB <= wbEnB_next;
      if (reqValid) begin
        wbIdxA <= rdIdxA;
        wbDataA <= wbDataA_next;
        wbIdxB <= rdIdxB;
        wbDataB <= yPtrNext;
      end
    end
  end

  // Count of memory issues, visible to software as block state.
  // A dual transfer counts once, not once per bus; the count wraps silently at 16 bits.
  always_ff @(posedge clock or negedge coreNrst) begin
    if (!coreNrst) begin
      issueCount_reg <= '0;
    end else if (memReq) begin
      issueCount_reg <= issueCount_reg + 16'h0001;
    end
  end

  // Wishbone: ack one cycle after the strobe, dropped the next cycle.
  // Keeping ack_reg out of the hit stops one long strobe from being taken twice.
  assign wbHit = wb_cyc_i & wb_stb_i & ~ack_reg;

  // One mask byte per select line, so a partial write leaves the other ring bytes alone.
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    assign wbMask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
  end

  // Every offset answers in one cycle, so a stray access never stalls the bus.
  always_ff @(posedge clock or negedge coreNrst) begin
    if (!coreNrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wbHit;
    end
  end

  // Writes land on the ack edge; byte lanes are honoured for the ring bounds.
  // Both ring enables live in the low byte of the control word, so its write needs lane 0.
  always_ff @(posedge clock or negedge coreNrst) begin
    if (!coreNrst) begin
      ctrl_reg <= `EA_CTRL_RST;
      ring_reg <= `EA_RING_RST;
    end else if (ack_reg && wb_cyc_i && wb_stb_i && wb_we_i) begin
      if (wb_adr_i == `EA_OFS_CTRL && wb_sel_i[0]) begin
        ctrl_reg <= wb_dat_i[1:0];
      end
      if (wb_adr_i == `EA_OFS_RING) begin
        ring_reg <= (ring_reg & ~wbMask) | (wb_dat_i & wbMask);
      end
    end
  end

  // Read data is captured as the ack is raised; unmapped offsets read as zero.
  // The captured word holds until the next access, so a slow master still sees it.
  always_ff @(posedge clock or negedge coreNrst) begin
    if (!coreNrst) begin
      rdat_reg <= '0;
    end else if (wbHit) begin
      unique case (wb_adr_i)
        `EA_OFS_CTRL: rdat_reg <= {30'h0000_0000, ctrl_reg};
        `EA_OFS_RING: rdat_reg <= ring_reg;
        `EA_OFS_STAT: rdat_reg <= {16'h0000, issueCount_reg};
        default: rdat_reg <= '0;
      endcase
    end
  end

  // Bus outputs come straight from their flops.
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

endmodule
`default_nettype wire

// ### verification/regfile_model.sv
// Register-file model that answers the generator's reads and takes its write-backs.
`timescale 1ns/1ns
`default_nettype none
module regfile_model (
  input wire logic clock,
  input wire logic [3:0] rdIdxA,
  output logic [31:0] rdDataA,
  input wire logic [3:0] rdIdxB,
  output logic [31:0] rdDataB,
  output logic [31:0] xIndexData,
  output logic [31:0] yIndexData,
  input wire logic wbEnA,
  input wire logic [3:0] wbIdxA,
  input wire logic [31:0] wbDataA,
  input wire logic wbEnB,
  input wire logic [3:0] wbIdxB,
  input wire logic [31:0] wbDataB
);
  logic [31:0] regs [16];
  // Reads are combinational so a request sees its operands in the cycle it is taken.
  assign rdDataA = regs[rdIdxA];
  assign rdDataB = regs[rdIdxB];
  assign xIndexData = regs[8];
  assign yIndexData = regs[9];
  // Write-backs land one edge late, so the bench spaces dependent requests.
  always @(posedge clock) begin
    if (wbEnA)
      regs[wbIdxA] <= wbDataA;
    if (wbEnB)
      regs[wbIdxB] <= wbDataB;
  end
endmodule
`default_nettype wire

// ### verification/cpu_dsp_address_generator_properties.sv
// Concurrent checks on the request and issue ports of the address generator.
`timescale 1ns/1ns
`default_nettype none
module cpu_dsp_address_generator_properties #(
  parameter int ADDR_W = 32
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic reqValid,
  input wire ea_pkg::req_class_t reqClass,
  input wire ea_pkg::cpu_mode_t cpuMode,
  input wire ea_pkg::op_size_t opSize,
  input wire logic [3:0] regSel,
  input wire ea_pkg::ptr_update_t xUpdate,
  input wire logic ySel,
  input wire ea_pkg::ptr_update_t yUpdate,
  input wire logic [3:0] rdIdxA,
  input wire logic [3:0] rdIdxB,
  input wire logic [ADDR_W-1:0] rdDataA,
  input wire logic [ADDR_W-1:0] rdDataB,
  input wire logic operandValid,
  input wire logic cpuBusReq,
  input wire logic [ADDR_W-1:0] cpuBusAddr,
  input wire logic xyBusReq,
  input wire logic [15:0] xBusAddr,
  input wire logic wbEnA,
  input wire logic [ADDR_W-1:0] wbDataA,
  input wire logic wbEnB,
  input wire logic [ADDR_W-1:0] wbDataB
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_direct_no_bus: assert property (
    reqValid && reqClass == ea_pkg::CLS_CPU && cpuMode == ea_pkg::CPU_DIRECT |=> operandValid && !cpuBusReq)
    else $error("direct mode reached the bus");
  a_indirect_keep: assert property (
    reqValid && reqClass == ea_pkg::CLS_CPU && cpuMode == ea_pkg::CPU_INDIRECT
    |=> cpuBusReq && cpuBusAddr == $past(rdDataA) && !wbEnA) else $error("indirect address wrong");
  a_postinc_step: assert property (
    reqValid && reqClass == ea_pkg::CLS_CPU && cpuMode == ea_pkg::CPU_POSTINC |=> cpuBusAddr == $past(rdDataA)
    && wbEnA && wbDataA == $past(rdDataA) + ($past(opSize) == ea_pkg::SZ_BYTE ? 1 : $past(opSize) == ea_pkg::SZ_WORD ? 2 : 4))
    else $error("post-increment wrong");
  a_predec_addr: assert property (
    reqValid && reqClass == ea_pkg::CLS_CPU && cpuMode == ea_pkg::CPU_PREDEC |=> wbEnA && cpuBusAddr == wbDataA)
    else $error("pre-decrement address differs from write-back");
  a_dual_ptrs: assert property (
    reqValid && reqClass == ea_pkg::CLS_DUAL |-> rdIdxA == {3'b010, regSel[0]} && rdIdxB == {3'b011, ySel})
    else $error("dual pointer register wrong");
  a_single_ptr: assert property (
    reqValid && reqClass == ea_pkg::CLS_SINGLE |-> rdIdxA == regSel[1:0] + 4'h2) else $error("single pointer wrong");
  a_single_dec: assert property (
    reqValid && reqClass == ea_pkg::CLS_SINGLE && xUpdate == ea_pkg::UPD_DEC |=> cpuBusAddr == wbDataA
    && cpuBusAddr == $past(rdDataA) - ($past(opSize) == ea_pkg::SZ_LONG ? 4 : 2)) else $error("single decrement wrong");
  a_xy_addr_low: assert property (
    reqValid && reqClass == ea_pkg::CLS_DUAL |=> xyBusReq && xBusAddr == {$past(rdDataA[15:1]), 1'b0})
    else $error("x bus address wrong");
  a_y_upper_kept: assert property (
    reqValid && reqClass == ea_pkg::CLS_DUAL && yUpdate != ea_pkg::UPD_NONE
    |=> wbEnB && wbDataB[31:16] == $past(rdDataB[31:16])) else $error("y upper half changed");
  a_dual_commit: assert property (
    reqValid && reqClass == ea_pkg::CLS_DUAL && xUpdate != ea_pkg::UPD_NONE && yUpdate != ea_pkg::UPD_NONE
    |=> wbEnA && wbEnB) else $error("dual write-backs split");
endmodule
bind cpu_dsp_address_generator cpu_dsp_address_generator_properties #(.ADDR_W(ADDR_W)) props (.clock, .nrst,
  .reqValid, .reqClass, .cpuMode, .opSize, .regSel, .xUpdate, .ySel, .yUpdate, .rdIdxA, .rdIdxB, .rdDataA,
  .rdDataB, .operandValid, .cpuBusReq, .cpuBusAddr, .xyBusReq, .xBusAddr, .wbEnA, .wbDataA, .wbEnB, .wbDataB);
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the address generator against a behavioural model.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, reqValid, ySel, xDestSel, yDestSel, operandValid;
  logic cpuBusReq, xyBusReq, xLoadSel, yLoadSel, wbEnA, wbEnB;
  logic [3:0] wb_adr_i, wb_sel_i, regSel, rdIdxA, rdIdxB, wbIdxA, wbIdxB;
  logic [31:0] wb_dat_i, wb_dat_o, rdDataA, rdDataB, xIndexData, yIndexData, operandData, cpuBusAddr, wbDataA, wbDataB;
  logic [15:0] xBusAddr, yBusAddr;
  ea_pkg::req_class_t reqClass;
  ea_pkg::cpu_mode_t cpuMode;
  ea_pkg::op_size_t opSize, cpuBusSize;
  ea_pkg::ptr_update_t xUpdate, yUpdate;
  int fails, checks_done, issues;
  logic [31:0] mdl [16];
  logic [31:0] ring, rdv;
  logic [1:0] ctrl;
  cpu_dsp_address_generator cpu_dsp_address_generator_inst (.clock, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reqValid, .reqClass, .cpuMode, .opSize, .regSel,
    .xUpdate, .ySel, .yUpdate, .xDestSel, .yDestSel, .rdIdxA, .rdDataA, .rdIdxB, .rdDataB, .xIndexData,
    .yIndexData, .operandValid, .operandData, .cpuBusReq, .cpuBusAddr, .cpuBusSize, .xyBusReq, .xBusAddr,
    .yBusAddr, .xLoadSel, .yLoadSel, .wbEnA, .wbIdxA, .wbDataA, .wbEnB, .wbIdxB, .wbDataB);
  regfile_model rf (.clock, .rdIdxA, .rdDataA, .rdIdxB, .rdDataB, .xIndexData, .yIndexData, .wbEnA, .wbIdxA,
    .wbDataA, .wbEnB, .wbIdxB, .wbDataB);
  // Free-running 25 MHz clock.
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic setr(input int i, input logic [31:0] v);
    mdl[i] = v;
    rf.regs[i] = v;
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clock);
    while (wb_ack_o !== 1'b1)
      @(posedge clock);
    rdv = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  // One request; outputs are judged a cycle later and the model then advances.
  task automatic req(input ea_pkg::req_class_t c, input ea_pkg::cpu_mode_t m, input ea_pkg::op_size_t s,
      input logic [3:0] r, input ea_pkg::ptr_update_t xu, input logic ys, input ea_pkg::ptr_update_t yu);
    logic [31:0] v, w, st, nx;
    @(posedge clock);
    reqValid <= 1;
    reqClass <= c;
    cpuMode <= m;
    opSize <= s;
    regSel <= r;
    xUpdate <= xu;
    ySel <= ys;
    yUpdate <= yu;
    xDestSel <= 1'($urandom);
    yDestSel <= 1'($urandom);
    @(posedge clock);
    reqValid <= 0;
    @(negedge clock);
    if (c == ea_pkg::CLS_CPU) begin
      v = mdl[r];
      st = s == ea_pkg::SZ_BYTE ? 1 : s == ea_pkg::SZ_WORD ? 2 : 4;
      nx = m == ea_pkg::CPU_POSTINC ? v + st : v - st;
      if (m == ea_pkg::CPU_DIRECT)
        chk("operand", v, operandData);
      else
        chk("cpu addr", m == ea_pkg::CPU_PREDEC ? nx : v, cpuBusAddr);
      chk("cpu bus req", m != ea_pkg::CPU_DIRECT, cpuBusReq);
      chk("operand valid", m == ea_pkg::CPU_DIRECT, operandValid);
      if (m != ea_pkg::CPU_DIRECT)
        chk("cpu size", s, cpuBusSize);
      chk("cpu wb en", m > ea_pkg::CPU_INDIRECT, wbEnA);
      if (m > ea_pkg::CPU_INDIRECT) begin
        chk("cpu wb", nx, wbDataA);
        mdl[r] = nx;
      end
      issues += m != ea_pkg::CPU_DIRECT;
    end else if (c == ea_pkg::CLS_SINGLE) begin
      r = 4'(r[1:0] + 2);
      v = mdl[r];
      st = s == ea_pkg::SZ_LONG ? 4 : 2;
      nx = xu == ea_pkg::UPD_INDEX ? v + mdl[8] : xu == ea_pkg::UPD_INC ? v + st : xu == ea_pkg::UPD_DEC ? v - st : v;
      chk("single addr", xu == ea_pkg::UPD_DEC ? nx : v, cpuBusAddr);
      chk("single size", s == ea_pkg::SZ_LONG ? 2 : 1, cpuBusSize);
      chk("single en", {xu != ea_pkg::UPD_NONE, 1'b1}, {wbEnA, cpuBusReq});
      if (xu != ea_pkg::UPD_NONE)
        chk("single wb", nx, wbDataA);
      mdl[r] = nx;
      issues++;
    end else if (c == ea_pkg::CLS_DUAL) begin
      v = mdl[4 + r[0]];
      w = mdl[6 + ys];
      chk("x addr", {v[15:1], 1'b0}, xBusAddr);
      chk("y addr", {w[15:1], 1'b0}, yBusAddr);
      chk("load sel", {xDestSel, yDestSel}, {xLoadSel, yLoadSel});
      chk("xy req", 2'h2, {xyBusReq, cpuBusReq});
      chk("wb en", {xu != ea_pkg::UPD_NONE, yu != ea_pkg::UPD_NONE}, {wbEnA, wbEnB});
      chk("wb idx", {4'(4 + r[0]), 4'(6 + ys)}, {wbIdxA, wbIdxB});
      st = xu == ea_pkg::UPD_INDEX ? mdl[8] : 2;
      nx = ctrl == 2'b01 && v[15:1] == ring[31:17] ? {v[31:16], ring[15:1], v[0]} : v + st;
      if (xu != ea_pkg::UPD_NONE) begin
        chk("x wb", nx, wbDataA);
        mdl[4 + r[0]] = nx;
      end
      st = yu == ea_pkg::UPD_INDEX ? mdl[9] : 2;
      nx = ctrl[1] && w[15:1] == ring[31:17] ? {w[31:16], ring[15:1], w[0]} : {w[31:16], w[15:0] + st[15:0]};
      if (yu != ea_pkg::UPD_NONE) begin
        chk("y wb", nx, wbDataB);
        mdl[6 + ys] = nx;
      end
      issues++;
    end else
      chk("refused", 0, {cpuBusReq, xyBusReq, wbEnA, wbEnB});
  endtask
  // Main sequence: register window, CPU modes, ring wrap, dual and single transfers.
  initial begin
    {fails, checks_done, issues, nrst, reqValid, wb_cyc_i, wb_stb_i, wb_we_i, ySel, xDestSel, yDestSel} = 0;
    {wb_adr_i, wb_dat_i, regSel, reqClass, cpuMode, opSize, xUpdate, yUpdate, ctrl} = 0;
    wb_sel_i = 4'hf;
    rdv = $urandom(75548);
    for (int i = 0; i < 16; i++)
      setr(i, $urandom & 32'hfffe_fffe);
    repeat (16) @(posedge clock);
    nrst <= 1;
    ring = 32'he00c_e008;
    wb_sel_i <= 4'h3;
    wb(1, 4'h4, 32'hffff_e008);
    wb_sel_i <= 4'hc;
    wb(1, 4'h4, 32'he00c_ffff);
    wb_sel_i <= 4'hf;
    wb(0, 4'h4, 0);
    chk("ring reg", ring, rdv);
    wb(0, 4'hc, 0);
    chk("unmapped", 0, rdv);
    $display("register window done");
    for (int k = 0; k < 24; k++)
      req(ea_pkg::CLS_CPU, ea_pkg::cpu_mode_t'(k % 4), ea_pkg::op_size_t'(k % 3), 4'($urandom), ea_pkg::UPD_NONE, 0, ea_pkg::UPD_NONE);
    $display("cpu modes done");
    ctrl = 2'b01;
    wb(1, 4'h0, ctrl);
    setr(4, 32'h1000_e008);
    repeat (3) req(ea_pkg::CLS_DUAL, ea_pkg::CPU_DIRECT, ea_pkg::SZ_WORD, 4'h0, ea_pkg::UPD_INC, 0, ea_pkg::UPD_NONE);
    ctrl = 2'b11;
    wb(1, 4'h0, ctrl);
    wb(0, 4'h0, 0);
    chk("ctrl reg", ctrl, rdv);
    setr(6, 32'h1234_e00c);
    setr(4, 32'h0000_e00c);
    req(ea_pkg::CLS_DUAL, ea_pkg::CPU_DIRECT, ea_pkg::SZ_WORD, 4'h0, ea_pkg::UPD_INC, 0, ea_pkg::UPD_INC);
    ctrl = 2'b00;
    wb(1, 4'h0, ctrl);
    $display("ring done");
    setr(8, 32'hffff_fffe);
    for (int k = 0; k < 18; k++)
      req(ea_pkg::CLS_DUAL, ea_pkg::CPU_DIRECT, ea_pkg::SZ_WORD, 4'($urandom), ea_pkg::ptr_update_t'(k % 3),
        1'($urandom), ea_pkg::ptr_update_t'(k / 3 % 3));
    for (int k = 0; k < 16; k++)
      req(ea_pkg::CLS_SINGLE, ea_pkg::CPU_DIRECT, ea_pkg::op_size_t'(1 + k % 2), 4'($urandom),
        ea_pkg::ptr_update_t'(k / 2 % 4), 0, ea_pkg::UPD_NONE);
    req(ea_pkg::CLS_NONE, ea_pkg::CPU_DIRECT, ea_pkg::SZ_WORD, 4'h4, ea_pkg::UPD_INC, 0, ea_pkg::UPD_INC);
    $display("transfers done");
    wb(1, 4'h8, 32'h0000_ffff);
    wb(0, 4'h8, 0);
    chk("issue count", 32'(issues), {16'h0, rdv[15:0]});
    final_report();
  end
  // About 60 requests and ten bus cycles need well under 1000 cycles.
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
